// *** design/psr_top.sv ***
// Status and interrupt request reporting of a two-channel position decoder
`timescale 1ns/1ns
module psr_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic job_wr,
	input wire logic [7:0] job_code,
	input wire logic rd_en,
	input wire logic [3:0] rd_offset,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic irq_req,
	input wire psr_pkg::psr_ch_in_t [1:0] ch_in,
	input wire logic [1:0] sync_pin
);
	import psr_pkg::*;

	// ==========================================================
	// Declarations
	psr_ch_state_t state_reg [NUM_CH]; // Per-channel state
	psr_ch_state_t state_next [NUM_CH];
	logic [1:0] pin_sync; // Sync pins after the synchronizer
	logic [1:0] pin_prev_reg; // Previous synchronized level
	logic [1:0] pin_prev_next;
	logic [1:0] pin_rise; // Rising edge of the sync input
	logic [1:0] pin_fall; // Falling edge of the sync input
	logic [1:0] stat_read; // Status record taken for a channel
	logic irq_read; // Request bytes taken
	logic [7:0] stat_hi [NUM_CH]; // Status byte at offset 2
	logic [7:0] stat_lo [NUM_CH]; // Status byte at offset 3
	logic [7:0] irq_hi [NUM_CH]; // First request byte
	logic [7:0] irq_lo [NUM_CH]; // Second request byte
	logic [7:0] rec [REC_BYTES]; // Record to be loaded
	logic [REC_BYTES*8-1:0] rec_flat; // Record, offset 0 in the top byte
	logic buf_load; // A known job was written

	// ==========================================================
	// Sync pins come from outside, so they pass two flip-flops first
	psr_sync2 #(
		.WIDTH(2)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.din(sync_pin),
		.dout(pin_sync)
	);

	// Edge detection on the synchronized level only
	always_comb begin
		pin_prev_next = pin_sync;
		pin_rise = pin_sync & ~pin_prev_reg;
		pin_fall = ~pin_sync & pin_prev_reg;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_prev_reg <= 2'b00;
		end else begin
			pin_prev_reg <= pin_prev_next;
		end
	end

	// ==========================================================
	// Job decode
	always_comb begin
		stat_read[0] = job_wr && (job_code == JOB_STAT_CH1);
		stat_read[1] = job_wr && (job_code == JOB_STAT_CH2);
		irq_read = job_wr && (job_code == JOB_IRQ);
		buf_load = stat_read[0] || stat_read[1] || irq_read;
	end

	// ==========================================================
	// Channel logic, one copy per channel with nothing shared
	// independent channels
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		// Next state of one channel
		always_comb begin
			psr_ch_state_t s;
			psr_ch_state_t n;
			psr_ch_in_t c;
			logic valid;
			logic [2:0] rng;
			logic fault;
			s = state_reg[g];
			c = ch_in[g];
			n = s;
			valid = 1'b0;
			rng = s.range;
			fault = 1'b0;

			// Host side clears come first so that a same-cycle event wins
			if (stat_read[g]) begin
				if (s.zero_mark_error) begin
					n.zero_mark_error = 1'b0;
				end
				if (s.overrange) begin
					n.overrange = 1'b0;
				end
				if (s.final_overwritten) begin
					n.final_overwritten = 1'b0;
				end
				// final value read ends measuring flag
				n.measure_done = 1'b0;
				n.final_unread = 1'b0;
				if (s.wirebreak) begin
					n.wb_ack = 1'b1;
				end
				if (s.ref_mode && !s.range[0]) begin
					n.r1_zero_read = 1'b1;
				end
			end
			if (irq_read) begin
				n.irq = '0;
				if (s.irq[IRQ_OV]) begin
					n.overrange = 1'b0;
				end
				if (s.irq[IRQ_ZM]) begin
					n.zero_mark_error = 1'b0;
				end
				if (s.irq[IRQ_FOW]) begin
					n.final_overwritten = 1'b0;
				end
				if (s.irq[IRQ_WB]) begin
					n.wb_ack = 1'b1;
				end
			end
			// clear only once the fault is gone
			if (n.wb_ack && !c.wirebreak_det) begin
				n.wirebreak = 1'b0;
				n.wb_ack = 1'b0;
			end

			// Mode changes: entering either sync mode invalidates the position
			n.ref_mode = c.ref_approach_select;
			n.ext_mode = c.external_sync_select;
			if (c.ref_approach_select && !s.ref_mode) begin
				n.pos_fb = POS_NONE;
				n.synced = 1'b0;
				n.r1_zero_read = 1'b0;
			end
			if (c.external_sync_select && !s.ext_mode) begin
				n.pos_fb = POS_NONE;
				n.synced = 1'b0;
			end
			// range2 sets when approach mode is left
			if (!c.ref_approach_select && s.ref_mode) begin
				n.range[1] = 1'b1;
			end

			if (c.soft_sync || (s.ref_mode && c.ref_point)) begin
				n.synced = 1'b1;
			end
			// rising edge synchronizes in external mode only
			if (s.ext_mode && pin_rise[g]) begin
				n.synced = 1'b1;
			end
			// falling edge captures the final value in external mode only
			if (s.ext_mode && pin_fall[g]) begin
				n.final_val = c.actual;
				n.measure_done = 1'b1;
				n.final_unread = 1'b1;
				n.irq[IRQ_MD] = n.irq[IRQ_MD] | c.irq_enable[IRQ_MD];
				// unread value replaced; a same-cycle read counts as delivered
				if (s.final_unread && !stat_read[g]) begin
					n.final_overwritten = 1'b1;
					n.irq[IRQ_FOW] = n.irq[IRQ_FOW] | c.irq_enable[IRQ_FOW];
				end
			end

			if (c.pos_select) begin
				n.pos_fb = c.pos_num;
				n.target_exited = 1'b0;
				n.reversal = 1'b0;
				n.fired = '0;
			end

			// Acquisition errors; detection beats any clear in the same cycle
			if (c.wirebreak_det) begin
				n.wirebreak = 1'b1;
				n.irq[IRQ_WB] = n.irq[IRQ_WB] | c.irq_enable[IRQ_WB];
				fault = 1'b1;
			end
			if (c.zero_mark_det) begin
				n.zero_mark_error = 1'b1;
				n.irq[IRQ_ZM] = n.irq[IRQ_ZM] | c.irq_enable[IRQ_ZM];
				fault = 1'b1;
			end
			if (c.overrange_det) begin
				n.overrange = 1'b1;
				n.irq[IRQ_OV] = n.irq[IRQ_OV] | c.irq_enable[IRQ_OV];
				fault = 1'b1;
			end
			if (fault) begin
				n.pos_fb = POS_NONE;
				n.synced = 1'b0;
			end

			if (c.cycle_tick) begin
				n.actual = c.actual;
				n.outputs = c.outputs;
				valid = n.synced && (n.pos_fb != POS_NONE);
				n.direction = !valid || c.target_neg;
				if (s.ref_mode) begin
					if (c.ref_prelim) begin
						rng[0] = 1'b0;
					end else if (n.r1_zero_read) begin
						rng[0] = 1'b1;
						n.r1_zero_read = 1'b0;
					end
					if (c.ref_point) begin
						rng[1] = 1'b0;
					end
				end else begin
					rng = ~({3{valid}} & c.in_range);
					if (valid && !s.range[2] && rng[2] && !n.fired[3]
						&& !(c.backlash && !c.approach_pos)) begin
						n.target_exited = 1'b1;
						n.fired[3] = 1'b1;
						n.irq[IRQ_TEX] = n.irq[IRQ_TEX] | c.irq_enable[IRQ_TEX];
					end
					if (valid && !s.range[1] && rng[1] && !n.fired[4]) begin
						n.reversal = 1'b1;
						n.fired[4] = 1'b1;
						n.irq[IRQ_REV] = n.irq[IRQ_REV] | c.irq_enable[IRQ_REV];
					end
				end
				// range entry raised once per position
				for (int k = 0; k < 3; k++) begin
					if (s.range[k] && !rng[k] && !n.fired[k]) begin
						if (k == 0 || !c.backlash || c.approach_pos || s.ref_mode) begin
							n.fired[k] = 1'b1;
							n.irq[IRQ_R1+k] = n.irq[IRQ_R1+k] | c.irq_enable[IRQ_R1+k];
						end
					end
				end
				n.range = rng;
			end
			state_next[g] = n;
		end

		// Register the channel state
		always_ff @(posedge clock) begin
			if (rst) begin
				state_reg[g] <= CH_STATE_RST;
			end else begin
				state_reg[g] <= state_next[g];
			end
		end

		// Byte images of the channel state
		always_comb begin
			stat_hi[g] = {2'b00, state_reg[g].reversal, state_reg[g].target_exited,
				state_reg[g].final_overwritten, state_reg[g].wirebreak,
				state_reg[g].zero_mark_error, state_reg[g].overrange};
			stat_lo[g] = {state_reg[g].outputs, state_reg[g].measure_done,
				state_reg[g].range, state_reg[g].direction, state_reg[g].synced};
			irq_hi[g] = {2'b00, state_reg[g].irq[IRQ_REV:IRQ_OV]};
			irq_lo[g] = {state_reg[g].direction, 1'b0, state_reg[g].irq[IRQ_MD],
				state_reg[g].irq[IRQ_R1+2:IRQ_R1], 2'b00};
		end
	end

	// ==========================================================
	// Record assembly for the job just written
	always_comb begin
		logic [31:0] act;
		logic [31:0] fin;
		int ch;
		ch = stat_read[1] ? 1 : 0;
		act = psr_encode(state_reg[ch].actual, ch_in[ch].bcd_mode);
		fin = psr_encode(state_reg[ch].final_val, ch_in[ch].bcd_mode);
		for (int i = 0; i < REC_BYTES; i++) begin
			rec[i] = 8'h00;
		end
		if (irq_read) begin
			rec[OFS_IRQ_CH1] = irq_hi[0];
			rec[OFS_IRQ_CH1+1] = irq_lo[0];
			rec[OFS_IRQ_CH2] = irq_hi[1];
			rec[OFS_IRQ_CH2+1] = irq_lo[1];
		end else begin
			// status record of the selected channel
			rec[OFS_ZERO] = 8'h00;
			rec[OFS_FBPOS] = state_reg[ch].pos_fb;
			rec[OFS_STAT_HI] = stat_hi[ch];
			rec[OFS_STAT_LO] = stat_lo[ch];
			for (int b = 0; b < 4; b++) begin
				rec[OFS_ACTUAL+b] = act[(3-b)*8 +: 8];
				rec[OFS_FINAL+b] = fin[(3-b)*8 +: 8];
			end
		end
		for (int i = 0; i < REC_BYTES; i++) begin
			rec_flat[(REC_BYTES-1-i)*8 +: 8] = rec[i];
		end
	end

	// ==========================================================
	// Transfer buffer; holds the last record until the next known job
	psr_xfer_buf #(
		.DEPTH(REC_BYTES)
	) u_buf (
		.clock(clock),
		.rst(rst),
		.load(buf_load),
		.load_data(rec_flat),
		.rd_en(rd_en),
		.rd_offset(rd_offset),
		.rd_data(rd_data),
		.rd_valid(rd_valid)
	);

	// ==========================================================
	// Request to the host; bits are only set when enabled
	always_comb begin
		irq_req = (|state_reg[0].irq) || (|state_reg[1].irq);
	end
endmodule // psr_top

// *** design/psr_pkg.sv ***
// Package of constants, carriers and the value encoder for the position status report block
package psr_pkg;

	// ==========================================================
	// Job codes and record layout
	localparam logic [7:0] JOB_STAT_CH1 = 8'h1B; // Status record of channel 1
	localparam logic [7:0] JOB_STAT_CH2 = 8'h2B; // Status record of channel 2
	localparam logic [7:0] JOB_IRQ = 8'h31; // Request bytes of both channels
	localparam int NUM_CH = 2; // Channels in the device
	localparam int REC_BYTES = 12; // Bytes of the transfer buffer
	localparam int OFS_ZERO = 0; // Leading zero byte of the status record
	localparam int OFS_FBPOS = 1; // Feedback position number
	localparam int OFS_STAT_HI = 2; // Error and event status bits
	localparam int OFS_STAT_LO = 3; // Output, range, direction, sync bits
	localparam int OFS_ACTUAL = 4; // Actual value, four bytes, high first
	localparam int OFS_FINAL = 8; // Final value, four bytes, high first
	localparam int OFS_IRQ_CH1 = 0; // Request bytes of channel 1, two bytes
	localparam int OFS_IRQ_CH2 = 2; // Request bytes of channel 2, two bytes

	// ==========================================================
	// Values and request bit positions
	localparam logic [7:0] POS_NONE = 8'hFF; // No valid position selected
	localparam logic [3:0] BCD_NEG = 4'hF; // Sign nibble of a negative BCD value
	localparam logic [3:0] BCD_POS = 4'h0; // Sign nibble of a positive BCD value
	localparam int IRQ_OV = 0; // Overrange
	localparam int IRQ_ZM = 1; // Zero mark error
	localparam int IRQ_WB = 2; // Wirebreak
	localparam int IRQ_FOW = 3; // Final value overwritten
	localparam int IRQ_TEX = 4; // Target range exited
	localparam int IRQ_REV = 5; // Reversal possible
	localparam int IRQ_R1 = 6; // Range 1 entered, ranges 2 and 3 follow
	localparam int IRQ_MD = 9; // Measuring done
	localparam int IRQ_BITS = 10; // Request bits per channel

	// ==========================================================
	// Per-channel inputs from the acquisition and positioning logic
	typedef struct packed {
		logic cycle_tick; // One pulse per processing cycle
		logic pos_select; // Pulse: new position number transferred
		logic [7:0] pos_num; // Number that comes with pos_select
		logic ref_approach_select; // Level: reference approach mode
		logic ref_prelim; // Level: preliminary contact reached
		logic ref_point; // Pulse: reference point reached
		logic soft_sync; // Pulse: software synchronization
		logic external_sync_select; // Level: external signal sync mode
		logic [2:0] in_range; // Level: actual within range 3..1
		logic target_neg; // Level: target lies below actual value
		logic approach_pos; // Level: current approach is from positive side
		logic wirebreak_det; // Level: broken encoder line seen
		logic zero_mark_det; // Pulse: zero mark error seen
		logic overrange_det; // Pulse: actual value entered overrange
		logic [1:0] outputs; // Level: output2, output1 state
		logic [23:0] actual; // Two's complement actual value
		logic bcd_mode; // Configuration: report in BCD
		logic backlash; // Configuration: backlash compensation
		logic [IRQ_BITS-1:0] irq_enable; // Configuration: enabled requests
	} psr_ch_in_t;

	// Per-channel held state
	typedef struct packed {
		logic [7:0] pos_fb; // Feedback position number
		logic synced; // Actual value synchronized
		logic direction; // Approach with descending value
		logic [2:0] range; // Range 3..1 outside flags
		logic target_exited; // Target range exited
		logic reversal; // Range 2 exited
		logic wirebreak; // Wirebreak status
		logic zero_mark_error; // Zero mark status
		logic overrange; // Overrange status
		logic measure_done; // Final value captured
		logic final_overwritten; // Unread final value replaced
		logic wb_ack; // Wirebreak has been reported
		logic r1_zero_read; // Range1 = 0 delivered in ref mode
		logic ref_mode; // Registered ref_approach_select
		logic ext_mode; // Registered external_sync_select
		logic final_unread; // Final value not yet delivered
		logic [1:0] outputs; // Output state, sampled per cycle
		logic [4:0] fired; // Range1..3, exit, reversal already raised
		logic [IRQ_BITS-1:0] irq; // Pending request bits
		logic [23:0] actual; // Actual value, sampled per cycle
		logic [23:0] final_val; // Captured final value
	} psr_ch_state_t;

	localparam psr_ch_state_t CH_STATE_RST = '{pos_fb: POS_NONE, direction: 1'b1,
		range: 3'b111, default: '0}; // Unsynced, no position

	// ==========================================================
	// Encode a value as sign-extended binary or as sign nibble plus seven BCD digits
	function automatic logic [31:0] psr_encode(input logic [23:0] v, input logic bcd);
		logic [23:0] mag;
		logic [27:0] d;
		mag = v[23] ? 24'(-v) : v;
		d = '0;
		for (int i = 23; i >= 0; i--) begin
			for (int k = 0; k < 7; k++) begin
				if (d[k*4 +: 4] >= 4'h5) begin
					d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
				end
			end
			d = {d[26:0], mag[i]};
		end
		if (bcd) begin
			return {(v[23] ? BCD_NEG : BCD_POS), d};
		end
		return {{8{v[23]}}, v};
	endfunction

endpackage

// *** design/psr_sync2.sv ***
// Two flip-flop synchronizer for the external sync pins
`timescale 1ns/1ns
module psr_sync2 #(
	parameter int WIDTH = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// ==========================================================
	// Stages
	logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] dout_next;

	// Next values are plain shifts
	always_comb begin
		meta_next = din;
		dout_next = meta_reg;
	end

	// Register both stages
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_reg <= '0;
			dout <= '0;
		end else begin
			meta_reg <= meta_next;
			dout <= dout_next;
		end
	end
endmodule // psr_sync2

// *** design/psr_xfer_buf.sv ***
// Transfer buffer: parallel record load, registered byte read
`timescale 1ns/1ns
module psr_xfer_buf #(
	parameter int DEPTH = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic [DEPTH*8-1:0] load_data,
	input wire logic rd_en,
	input wire logic [3:0] rd_offset,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	// ==========================================================
	// Storage
	logic [7:0] mem_reg [DEPTH]; // Record bytes, offset order
	logic [7:0] mem_next [DEPTH];
	logic [7:0] rd_data_next;
	logic rd_valid_next;

	// Load the whole record at once; reads beyond the record answer zero
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = load ? load_data[(DEPTH-1-i)*8 +: 8] : mem_reg[i];
		end
		rd_valid_next = rd_en;
		rd_data_next = 8'h00;
		if (rd_en && (int'(rd_offset) < DEPTH)) begin
			rd_data_next = mem_reg[rd_offset];
		end
	end

	// Register storage and read port
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= 8'h00;
			end
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			mem_reg <= mem_next;
			rd_data <= rd_data_next;
			rd_valid <= rd_valid_next;
		end
	end
endmodule // psr_xfer_buf

// *** verif/psr_top_chk.sv ***
// Port checker of the status and request report block
`timescale 1ns/1ns
module psr_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic job_wr,
	input wire logic [7:0] job_code,
	input wire logic rd_en,
	input wire logic [3:0] rd_offset,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic irq_req,
	input wire psr_pkg::psr_ch_in_t [1:0] ch_in,
	input wire logic [1:0] sync_pin
);
	import psr_pkg::*;
	// ==========================================================
	// Helper state
	logic [1:0] kind_reg; // Buffer holds 0 nothing, 1 status, 2 requests
	logic [1:0] kind_next;
	logic quiet; // No tick, position select or error detection active on any channel
	// Track the record kind; unknown codes leave it alone
	always_comb begin
		kind_next = kind_reg;
		if (job_wr && (job_code == JOB_STAT_CH1 || job_code == JOB_STAT_CH2)) begin
			kind_next = 2'h1;
		end else if (job_wr && job_code == JOB_IRQ) begin
			kind_next = 2'h2;
		end
		if (rst) begin
			kind_next = 2'h0;
		end
		quiet = 1'b1;
		for (int c = 0; c < NUM_CH; c++) begin
			if (ch_in[c].cycle_tick || ch_in[c].pos_select || ch_in[c].wirebreak_det
				|| ch_in[c].zero_mark_det || ch_in[c].overrange_det) begin
				quiet = 1'b0;
			end
		end
	end
	always_ff @(posedge clock) begin
		kind_reg <= kind_next;
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_RD_VALID: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	AST_RD_IDLE: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
		else $error("read data not cleared without a request");
	AST_RD_HIGH: assert property (rd_en && rd_offset >= 4'hC |=> rd_data == 8'h00)
		else $error("byte past the record not zero");
	AST_STAT_LEAD: assert property (rd_en && kind_reg == 2'h1 && rd_offset == 4'h0
		|=> rd_data == 8'h00)
		else $error("status lead byte not zero");
	AST_STAT_TOP: assert property (rd_en && kind_reg == 2'h1 && rd_offset == 4'h2
		|=> rd_data[7:6] == 2'h0)
		else $error("status top bits not zero");
	AST_IRQ_PAD: assert property (rd_en && kind_reg == 2'h2 && rd_offset >= 4'h4
		|=> rd_data == 8'h00)
		else $error("request record padding not zero");
	AST_IRQ_LO: assert property (rd_en && kind_reg == 2'h2 && rd_offset[0]
		|=> rd_data[6] == 1'b0 && rd_data[1:0] == 2'h0)
		else $error("request low byte spare bits set");
	AST_IRQ_CLR: assert property ($stable(sync_pin)[*5] ##0
		(job_wr && job_code == JOB_IRQ && quiet) |=> !irq_req)
		else $error("request not withdrawn by request read");
	AST_IRQ_HOLD: assert property (irq_req && !(job_wr && job_code == JOB_IRQ)
		|=> irq_req)
		else $error("request dropped without a read");
endmodule // psr_chk

bind psr_top psr_chk psr_chk_i (
	.clock(clock), .rst(rst), .job_wr(job_wr), .job_code(job_code),
	.rd_en(rd_en), .rd_offset(rd_offset), .rd_data(rd_data), .rd_valid(rd_valid),
	.irq_req(irq_req), .ch_in(ch_in), .sync_pin(sync_pin)
);

// *** verif/psr_host.sv ***
// Host model: writes job codes and reads the transfer buffer
`timescale 1ns/1ns
module psr_host (
	input wire logic clock,
	output logic job_wr,
	output logic [7:0] job_code,
	output logic rd_en,
	output logic [3:0] rd_offset,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	// Idle bus at time zero
	initial begin
		job_wr = 1'b0;
		job_code = 8'h00;
		rd_en = 1'b0;
		rd_offset = 4'h0;
	end
	// job code strobe
	// Code is scrambled once the strobe drops, so stale values are never relied on
	task automatic job(input logic [7:0] c);
		@(posedge clock);
		job_wr <= 1'b1;
		job_code <= c;
		@(posedge clock);
		job_wr <= 1'b0;
		job_code <= ~c;
	endtask
	// Byte read; the answer lands one cycle after the request edge
	task automatic rd(input logic [3:0] o, output logic [7:0] d, output logic v);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_offset <= o;
		@(posedge clock);
		rd_en <= 1'b0;
		rd_offset <= ~o;
		#1;
		d = rd_data;
		v = rd_valid;
	endtask
endmodule // psr_host

// *** verif/psr_top_tb_top.sv ***
// Self-checking testbench of the status and request report block
`timescale 1ns/1ns
module psr_top_tb_top;
	import psr_pkg::*;
	// Table row: job, channel 1 format, offset, expected byte
	typedef struct packed {
		logic [7:0] code;
		logic bcd;
		logic [3:0] ofs;
		logic [7:0] exp;
	} psr_row_t;
	localparam psr_row_t ROWS [14] = '{
		'{8'h1B, 1'b0, 4'h4, 8'hFF}, '{8'h1B, 1'b0, 4'h7, 8'hFB},
		'{8'h1B, 1'b1, 4'h4, 8'hF0}, '{8'h1B, 1'b1, 4'h7, 8'h05},
		'{8'h1B, 1'b0, 4'h8, 8'h00}, '{8'h2B, 1'b0, 4'h4, 8'h01},
		'{8'h2B, 1'b0, 4'h5, 8'h23}, '{8'h2B, 1'b0, 4'h6, 8'h45},
		'{8'h2B, 1'b0, 4'h7, 8'h67}, '{8'h2B, 1'b0, 4'h1, 8'hFF},
		'{8'h2B, 1'b0, 4'h3, 8'h1E}, '{8'h31, 1'b0, 4'h1, 8'h80},
		'{8'h31, 1'b0, 4'h3, 8'h80}, '{8'h2B, 1'b0, 4'hC, 8'h00}};
	logic clock;
	logic rst;
	logic job_wr;
	logic [7:0] job_code;
	logic rd_en;
	logic [3:0] rd_offset;
	logic [7:0] rd_data;
	logic rd_valid;
	logic irq_req;
	psr_ch_in_t [1:0] ch; // Channel inputs
	logic [1:0] sync_pin;
	int err_total;
	int n_checks;
	psr_top psr_top_i (.clock(clock), .rst(rst), .job_wr(job_wr), .job_code(job_code),
		.rd_en(rd_en), .rd_offset(rd_offset), .rd_data(rd_data), .rd_valid(rd_valid),
		.irq_req(irq_req), .ch_in(ch), .sync_pin(sync_pin));
	psr_host psr_host_i (.clock(clock), .job_wr(job_wr), .job_code(job_code),
		.rd_en(rd_en), .rd_offset(rd_offset), .rd_data(rd_data), .rd_valid(rd_valid));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Read one byte and check both the valid flag and the data
	task automatic rb(input logic [3:0] o, input logic [7:0] e);
		logic [7:0] dv;
		logic vv;
		psr_host_i.rd(o, dv, vv);
		chk({7'h0, vv}, 8'h01);
		chk(dv, e);
	endtask
	// One-hot event drive on channel 1; 4 ticks both channels, 9 idles
	task automatic drive(input int k);
		@(posedge clock);
		ch[0].soft_sync <= (k == 0);
		ch[0].pos_select <= (k == 1);
		ch[0].overrange_det <= (k == 2);
		ch[0].zero_mark_det <= (k == 3);
		ch[0].cycle_tick <= (k == 4);
		ch[1].cycle_tick <= (k == 4);
	endtask
	task automatic pulse(input int k);
		drive(k);
		drive(9);
	endtask
	// Rise then fall of channel 2 sync pin; waits cover the pin latency
	task automatic cap(input logic [23:0] a);
		@(posedge clock);
		ch[1].actual <= a;
		sync_pin[1] <= 1'b1;
		repeat (5) @(posedge clock);
		sync_pin[1] <= 1'b0;
		repeat (5) @(posedge clock);
	endtask
	// ==========================================================
	// Clock and main sequence
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		err_total = 0;
		n_checks = 0;
		rst = 1'b1;
		ch = '0;
		ch[0].irq_enable = '1;
		ch[1].irq_enable = '1;
		ch[0].actual = 24'hFFFFFB;
		ch[1].actual = 24'h12D687;
		ch[1].bcd_mode = 1'b1;
		sync_pin = 2'h0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h1, 8'hFF);
		rb(4'h3, 8'h1E);
		chk({7'h0, irq_req}, 8'h00);
		pulse(4);
		// Table of plain record reads
		for (int i = 0; i < 14; i++) begin
			@(posedge clock);
			ch[0].bcd_mode <= ROWS[i].bcd;
			psr_host_i.job(ROWS[i].code);
			rb(ROWS[i].ofs, ROWS[i].exp);
		end
		// Sync, select a position, enter all ranges
		@(posedge clock);
		ch[0].pos_num <= 8'h07;
		ch[0].in_range <= 3'h7;
		pulse(0);
		pulse(1);
		pulse(4);
		#1;
		chk({7'h0, irq_req}, 8'h01);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h1, 8'h07);
		rb(4'h3, 8'h01);
		psr_host_i.job(JOB_IRQ);
		rb(4'h1, 8'h1C);
		rb(4'h3, 8'h80);
		chk({7'h0, irq_req}, 8'h00);
		// Leave and re-enter ranges 2 and 3 under one position
		@(posedge clock);
		ch[0].in_range <= 3'h1;
		pulse(4);
		psr_host_i.job(JOB_IRQ);
		rb(4'h0, 8'h30);
		@(posedge clock);
		ch[0].in_range <= 3'h7;
		pulse(4);
		psr_host_i.job(JOB_IRQ);
		rb(4'h1, 8'h00);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h30);
		pulse(1);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h00);
		// Overrange and zero mark, cleared by either read
		pulse(2);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h1, 8'hFF);
		rb(4'h2, 8'h01);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h00);
		psr_host_i.job(JOB_IRQ);
		rb(4'h0, 8'h01);
		pulse(3);
		psr_host_i.job(JOB_IRQ);
		rb(4'h0, 8'h02);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h00);
		// Wirebreak stays while the fault lasts
		@(posedge clock);
		ch[0].wirebreak_det <= 1'b1;
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h04);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h04);
		@(posedge clock);
		ch[0].wirebreak_det <= 1'b0;
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h00);
		psr_host_i.job(JOB_IRQ);
		rb(4'h0, 8'h04);
		// Final value capture on channel 2
		cap(24'h000009);
		psr_host_i.job(JOB_STAT_CH2);
		rb(4'h3, 8'h1E);
		rb(4'hB, 8'h00);
		@(posedge clock);
		ch[1].external_sync_select <= 1'b1;
		cap(24'h000100);
		psr_host_i.job(JOB_STAT_CH2);
		rb(4'h3, 8'h3F);
		rb(4'hA, 8'h02);
		rb(4'hB, 8'h56);
		cap(24'h000005);
		cap(24'hFFFFF6);
		psr_host_i.job(JOB_STAT_CH2);
		rb(4'h2, 8'h08);
		rb(4'h8, 8'hF0);
		rb(4'hB, 8'h10);
		psr_host_i.job(JOB_IRQ);
		rb(4'h2, 8'h08);
		rb(4'h3, 8'hA0);
		// Backlash blocks exit and range2/3 requests; range1 request disabled
		@(posedge clock);
		ch[0].backlash <= 1'b1;
		ch[0].irq_enable[IRQ_R1] <= 1'b0;
		ch[0].in_range <= 3'h0;
		ch[0].target_neg <= 1'b1;
		ch[0].outputs <= 2'h3;
		pulse(0);
		pulse(1);
		pulse(4);
		@(posedge clock);
		ch[0].in_range <= 3'h7;
		pulse(4);
		psr_host_i.job(JOB_IRQ);
		rb(4'h0, 8'h20);
		rb(4'h1, 8'h80);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h2, 8'h20);
		rb(4'h3, 8'hC3);
		// Reference approach: range1 follows the contact and the read-out
		@(posedge clock);
		ch[0].ref_approach_select <= 1'b1;
		ch[0].ref_prelim <= 1'b1;
		pulse(4);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h1, 8'hFF);
		rb(4'h3, 8'hC2);
		@(posedge clock);
		ch[0].ref_prelim <= 1'b0;
		pulse(4);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h3, 8'hC6);
		@(posedge clock);
		ch[0].ref_prelim <= 1'b1;
		pulse(4);
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h3, 8'hC2);
		@(posedge clock);
		ch[0].ref_approach_select <= 1'b0;
		psr_host_i.job(JOB_STAT_CH1);
		rb(4'h3, 8'hCA);
		close_out();
	end
endmodule // psr_top_tb_top
